// [inc/trs_cfg.svh]
// constants for the trap return sequencer: vector numbers and fixed addresses
`ifndef TRS_CFG_SVH
`define TRS_CFG_SVH
// emulation vector for the double-result floating multiply
`define TRS_VEC_FMUL 8'h39
// reserved emulation vectors, inclusive range
`define TRS_VEC_EMU_LO 8'h3A
`define TRS_VEC_EMU_HI 8'h3F
// first vector supplied by assert and emulate instructions (up to 255)
`define TRS_VEC_INST_LO 8'h40
// instruction ROM word address where the fatal-alert handler starts
`define TRS_FATAL_ROM_ADDR 32'h0000_0010
// default vector of the first external event line
`define TRS_EVT_VEC_BASE 8'h10
// reset value of the current status word
`define TRS_STATUS_RST 14'h0000
`endif

// [inc/trs_pkg.sv]
// types shared by the trap return sequencer files
package trs_pkg;
  // current/old status word; mask bit i enables event line i
  typedef struct packed {
    logic irq_pending;          // hardware-maintained, never copied
    logic rom_fetch_flag;       // fetch from instruction ROM when set
    logic freeze_flag;          // holds channel, pc and alu status
    logic all_event_block_flag; // blocks every maskable event
    logic irq_block_flag;       // blocks interrupt-type events
    logic [7:0] interrupt_mask_field;
    logic spare;                // unused, reads back as written
  } trs_status_t;

  // channel control bits that steer the restart
  typedef struct packed {
    logic channel_valid_flag;
    logic skip_restart_flag;
    logic multi_transfer_flag;
  } trs_chan_t;

  // class of a vector number
  typedef enum logic [1:0] {
    TRS_VK_SYS = 2'h0,
    TRS_VK_FMUL = 2'h1,
    TRS_VK_EMU = 2'h2,
    TRS_VK_INST = 2'h3
  } trs_vkind_t;

  // return sequencer states, one-hot
  typedef enum logic [9:0] {
    TRS_IDLE = 10'h001,
    TRS_WAIT = 10'h002,
    TRS_COPY = 10'h004,
    TRS_ACC = 10'h008,
    TRS_FET1 = 10'h010,
    TRS_DEC1 = 10'h020,
    TRS_FET2 = 10'h040,
    TRS_ADV = 10'h080,
    TRS_MULT = 10'h100,
    TRS_DONE = 10'h200
  } trs_state_t;
endpackage

// [verilog/trs_prio_pick.sv]
// fixed-priority picker: lowest index wins
module trs_prio_pick #(
  parameter int N = 8
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [$clog2(N)-1:0] o_idx
);
  // a single line has nothing to pick between and breaks the index width
  if (N < 2)
  begin : g_bad
    $error("trs_prio_pick needs at least two lines");
  end

  // scan from the lowest priority up so the highest one is written last
  always_comb
  begin
    o_any = |i_req;
    o_idx = '0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (i_req[i])
      begin
        o_idx = i[$clog2(N)-1:0];
      end
    end
  end
endmodule // trs_prio_pick

// [verilog/trs_trap_return_seq.sv]
// trap return sequencing, freeze-mode guards and fatal-alert trap entry
`include "trs_cfg.svh"
// Notes on behaviour
// - classify vector 57, 58-63, 64-255
// - return waits out load/store multiple
// - block maskable events steps 3 to 10
// - flushing return clears branch cache valids
// - copy old status, keep hardware bits
// - restart single access when valid, not multi
// - fetch first address as branch, decode
// - fetch second address, advance pipeline
// - sequential second fetch when pcs unchanged
// - restart multiple transfer after both fetches
// - reenable events and resume at end
// - no load/store multiple while frozen
// - byte pointer unchanged while frozen
// - carry not updated while frozen
// - divide flag not updated while frozen
// - fatal alert trap cannot be masked
// - fatal alert does not wait for access
// - fatal alert sets rom flag, fetch 16
// - each cycle pick highest pending event
// - freeze holds channel, pcs, alu status
// - rom flag steers instruction fetch target
module trs_trap_return_seq #(
  parameter int NEV = 8,
  parameter logic [7:0] EVT_VEC_BASE = `TRS_EVT_VEC_BASE
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ret_req,            // trap_return_op issued
  input wire logic i_ret_flush,          // with i_ret_req: trap_return_flush_op
  input wire logic i_multi_busy,         // load/store multiple in progress
  input wire logic i_access_busy,        // single external access in progress
  input wire trs_pkg::trs_status_t i_old_status,
  input wire logic i_status_we,          // software write of current status
  input wire trs_pkg::trs_status_t i_status_wdata,
  input wire trs_pkg::trs_chan_t i_chan_ctl,
  input wire logic [31:0] i_pc1,
  input wire logic [31:0] i_pc0,
  input wire logic i_pc_seq,             // pcs sequential and untouched
  input wire logic i_inst_trap,          // trapping instruction
  input wire logic [7:0] i_inst_vec,
  input wire logic [NEV-1:0] i_evt_req,  // index 0 is highest priority
  input wire logic [NEV-1:0] i_evt_is_irq,
  input wire logic i_fatal_alert,        // asynchronous pin, active high
  input wire logic i_lsm_req,
  input wire logic i_sbp_req,            // load/store with set_byte_ptr_flag
  input wire logic i_carry_upd,
  input wire logic i_div_upd,
  output trs_pkg::trs_status_t o_status,
  output logic o_ret_block,
  output logic o_btc_flush,
  output logic o_acc_start,
  output logic o_fetch_req,
  output logic [31:0] o_fetch_addr,
  output logic o_fetch_branch,
  output logic o_fetch_rom,
  output logic o_dec_load,
  output logic o_exe_advance,
  output logic o_multi_restart,
  output logic o_ret_done,
  output logic o_take,
  output logic o_take_fatal,
  output logic [7:0] o_take_vec,
  output trs_pkg::trs_vkind_t o_vec_kind,
  output logic o_hold_regs,
  output logic o_lsm_grant,
  output logic o_sbp_we,
  output logic o_carry_we,
  output logic o_div_we
);
  import trs_pkg::*;

  localparam int IW = $clog2(NEV);

  // the status mask field is eight bits, so more lines cannot be masked
  if (NEV < 2 || NEV > 8)
  begin : g_bad
    $error("NEV must lie between 2 and 8");
  end

  // whole module state in one word
  typedef struct packed {
    trs_state_t st;
    trs_status_t status;
    logic [2:0] sync;      // fatal pin synchroniser, bit 0 first
    logic fatal_lvl;       // filtered pin level
    logic fatal_prev;
    logic ret_flush;       // return is the flushing variant
    logic ret_block;
    logic btc_flush;
    logic acc_start;
    logic fetch_req;
    logic [31:0] fetch_addr;
    logic fetch_branch;
    logic fetch_rom;
    logic dec_load;
    logic exe_advance;
    logic multi_restart;
    logic ret_done;
    logic take;
    logic take_fatal;
    logic [7:0] take_vec;
    trs_vkind_t vec_kind;
    logic hold_regs;
    logic lsm_grant;
    logic sbp_we;
    logic carry_we;
    logic div_we;
  } trs_state_word_t;

  trs_state_word_t r;
  trs_state_word_t n;
  logic [NEV-1:0] evt_ok;  // events that may be taken now
  logic evt_any;
  logic [IW-1:0] evt_idx;
  logic fatal_rise;
  logic blk_now;           // maskable events blocked this cycle

  // steps 3 to 10 of the return: disable regardless of the status fields
  function automatic logic in_win(input trs_state_t s);
    in_win = (s == TRS_COPY) || (s == TRS_ACC) || (s == TRS_FET1) ||
      (s == TRS_DEC1) || (s == TRS_FET2) || (s == TRS_ADV) || (s == TRS_MULT);
  endfunction

  // vector number class
  function automatic trs_vkind_t vkind(input logic [7:0] v);
    if (v >= `TRS_VEC_INST_LO)
      vkind = TRS_VK_INST;
    else if (v >= `TRS_VEC_EMU_LO && v <= `TRS_VEC_EMU_HI)
      vkind = TRS_VK_EMU;
    else if (v == `TRS_VEC_FMUL)
      vkind = TRS_VK_FMUL;
    else
      vkind = TRS_VK_SYS;
  endfunction

  // fatal alert edge on the filtered level
  assign fatal_rise = r.fatal_lvl && !r.fatal_prev;

  // status blocks and the return window gate every maskable source
  assign blk_now = in_win(r.st) || r.status.all_event_block_flag;
  assign evt_ok = blk_now ? '0 :
    i_evt_req & r.status.interrupt_mask_field[NEV-1:0] &
    ~(i_evt_is_irq & {NEV{r.status.irq_block_flag}});

  // highest pending event line
  trs_prio_pick #(
    .N(NEV)
  ) u_pick (
    .i_req(evt_ok),
    .o_any(evt_any),
    .o_idx(evt_idx)
  );

  // next-state logic
  always_comb
  begin
    n = r;
    // pulses default low
    n.btc_flush = 1'b0;
    n.acc_start = 1'b0;
    n.fetch_req = 1'b0;
    n.dec_load = 1'b0;
    n.exe_advance = 1'b0;
    n.multi_restart = 1'b0;
    n.ret_done = 1'b0;
    n.take = 1'b0;
    n.take_fatal = 1'b0;
    // three-stage synchroniser; accept a change once stages 2 and 3 agree
    n.sync = {r.sync[1:0], i_fatal_alert};
    if (r.sync[1] == r.sync[2])
    begin
      n.fatal_lvl = r.sync[2];
    end
    n.fatal_prev = r.fatal_lvl;
    // software write of the current status
    if (i_status_we)
    begin
      n.status = i_status_wdata;
    end
    // sequencer
    case (r.st)
      TRS_IDLE:
      begin
        if (i_ret_req)
        begin
          n.ret_flush = i_ret_flush;
          n.st = TRS_WAIT;
        end
      end
      TRS_WAIT:
      begin
        // finish any access; a multiple sequence must end first
        if (!i_multi_busy && !i_access_busy)
        begin
          n.st = TRS_COPY;
        end
      end
      TRS_COPY:
      begin
        n.btc_flush = r.ret_flush;
        n.status = i_old_status;
        n.st = TRS_ACC;
      end
      TRS_ACC:
      begin
        // one plain access restarts here, multiples wait for later
        n.acc_start = i_chan_ctl.channel_valid_flag &&
          !i_chan_ctl.skip_restart_flag && !i_chan_ctl.multi_transfer_flag;
        n.st = TRS_FET1;
      end
      TRS_FET1:
      begin
        n.fetch_req = 1'b1;
        n.fetch_addr = i_pc1;
        n.fetch_branch = 1'b1;
        n.fetch_rom = r.status.rom_fetch_flag;
        n.st = TRS_DEC1;
      end
      TRS_DEC1:
      begin
        n.dec_load = 1'b1;
        n.st = TRS_FET2;
      end
      TRS_FET2:
      begin
        n.fetch_req = 1'b1;
        n.fetch_addr = i_pc0;
        n.fetch_branch = !i_pc_seq;
        n.fetch_rom = r.status.rom_fetch_flag;
        n.st = TRS_ADV;
      end
      TRS_ADV:
      begin
        n.exe_advance = 1'b1;
        n.dec_load = 1'b1;
        n.st = TRS_MULT;
      end
      TRS_MULT:
      begin
        n.multi_restart = i_chan_ctl.channel_valid_flag &&
          !i_chan_ctl.skip_restart_flag && i_chan_ctl.multi_transfer_flag;
        n.st = TRS_DONE;
      end
      TRS_DONE:
      begin
        // window closes: status fields alone gate events again
        n.ret_done = 1'b1;
        n.st = TRS_IDLE;
      end
      default:
      begin
        n.st = TRS_IDLE;
      end
    endcase
    // every cycle: run on, or take the highest pending event
    if (fatal_rise)
    begin
      // no mask, no window, no wait for the access; channel stays frozen
      n.take = 1'b1;
      n.take_fatal = 1'b1;
      n.take_vec = 8'h00;
      n.status.freeze_flag = 1'b1;
      n.status.all_event_block_flag = 1'b1;
      n.status.rom_fetch_flag = 1'b1;
      n.fetch_req = 1'b1;
      n.fetch_addr = `TRS_FATAL_ROM_ADDR;
      n.fetch_branch = 1'b1;
      n.fetch_rom = 1'b1;
      n.st = TRS_IDLE;
    end
    else if (!blk_now && !i_access_busy && (i_inst_trap || evt_any))
    begin
      n.take = 1'b1;
      if (i_inst_trap)
      begin
        n.take_vec = i_inst_vec;
      end
      else
      begin
        n.take_vec = EVT_VEC_BASE + 8'(evt_idx);
      end
      n.vec_kind = vkind(n.take_vec);
      n.status.freeze_flag = 1'b1;
      n.status.all_event_block_flag = 1'b1;
      n.st = TRS_IDLE;
    end
    // pending bit always follows the hardware, whatever was copied
    n.status.irq_pending = |(i_evt_req & i_evt_is_irq);
    n.ret_block = in_win(n.st);
    // freeze guards, sampled on the current status
    n.hold_regs = r.status.freeze_flag;
    n.lsm_grant = i_lsm_req && !r.status.freeze_flag;
    n.sbp_we = i_sbp_req && !r.status.freeze_flag;
    n.carry_we = i_carry_upd && !r.status.freeze_flag;
    n.div_we = i_div_upd && !r.status.freeze_flag;
  end

  // state register, synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      r <= '0;
      r.st <= TRS_IDLE;
      r.status <= `TRS_STATUS_RST;
      r.vec_kind <= TRS_VK_SYS;
    end
    else
    begin
      r <= n;
    end
  end

  // outputs straight from the state word
  assign o_status = r.status;
  assign o_ret_block = r.ret_block;
  assign o_btc_flush = r.btc_flush;
  assign o_acc_start = r.acc_start;
  assign o_fetch_req = r.fetch_req;
  assign o_fetch_addr = r.fetch_addr;
  assign o_fetch_branch = r.fetch_branch;
  assign o_fetch_rom = r.fetch_rom;
  assign o_dec_load = r.dec_load;
  assign o_exe_advance = r.exe_advance;
  assign o_multi_restart = r.multi_restart;
  assign o_ret_done = r.ret_done;
  assign o_take = r.take;
  assign o_take_fatal = r.take_fatal;
  assign o_take_vec = r.take_vec;
  assign o_vec_kind = r.vec_kind;
  assign o_hold_regs = r.hold_regs;
  assign o_lsm_grant = r.lsm_grant;
  assign o_sbp_we = r.sbp_we;
  assign o_carry_we = r.carry_we;
  assign o_div_we = r.div_we;

  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_RET_WAITS: assert property (
    o_btc_flush |-> !$past(i_multi_busy, 2))
    else $error("return went ahead during a multiple transfer");
  AST_NO_TAKE_IN_WIN: assert property (
    o_take && !o_take_fatal |-> !$past(blk_now))
    else $error("maskable event taken while blocked");
  AST_FLUSH_VARIANT: assert property (
    r.st == TRS_COPY && !fatal_rise |=> o_btc_flush == $past(r.ret_flush))
    else $error("cache flush does not match return variant");
  AST_STATUS_COPY: assert property (
    r.st == TRS_COPY && !fatal_rise |=>
      o_status.freeze_flag == $past(i_old_status.freeze_flag))
    else $error("old status not copied");
  AST_ACC_RESTART: assert property (
    o_acc_start |-> $past(i_chan_ctl.channel_valid_flag &&
      !i_chan_ctl.multi_transfer_flag && !i_chan_ctl.skip_restart_flag))
    else $error("access restart without valid single transfer");
  AST_FETCH_THEN_DECODE: assert property (
    r.st == TRS_FET1 && !fatal_rise |=> o_fetch_req && o_fetch_branch ##1 o_dec_load)
    else $error("first return fetch not a branch followed by decode");
  AST_SEQ_FETCH: assert property (
    r.st == TRS_FET2 && i_pc_seq && !fatal_rise |=> o_fetch_req && !o_fetch_branch)
    else $error("second fetch not sequential");
  AST_MULTI_AFTER: assert property (
    o_multi_restart |-> $past(o_exe_advance))
    else $error("multiple restart out of order");
  AST_LSM_FROZEN: assert property (
    o_lsm_grant |-> !$past(o_status.freeze_flag))
    else $error("multiple granted while frozen");
  AST_CARRY_FROZEN: assert property (
    o_status.freeze_flag |=> !o_carry_we)
    else $error("carry updated while frozen");
  AST_FATAL_ENTRY: assert property (
    fatal_rise |=> o_take_fatal && o_fetch_rom && o_status.rom_fetch_flag &&
      o_fetch_addr == `TRS_FATAL_ROM_ADDR)
    else $error("fatal alert entry wrong");
endmodule // trs_trap_return_seq

// [tb/trs_chan_model.sv]
// channel partner: external memory side that answers restarted transfers
module trs_chan_model #(
  parameter int LAT = 2
) (
  input wire logic i_clk,
  input wire logic i_acc_start,     // restarted single access from the sequencer
  input wire logic i_multi_restart, // restarted load/store multiple
  input wire logic i_hold_acc,      // bench keeps an access outstanding
  input wire logic i_hold_multi,    // bench keeps a multiple transfer running
  output logic o_access_busy,
  output logic o_multi_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int acc_cnt = 0; // cycles left on the single access
  int mul_cnt = 0; // cycles left on the multiple transfer

  // a restart occupies the channel for LAT cycles, changed just after the edge
  always @(posedge i_clk)
  begin
    acc_cnt <= i_acc_start ? LAT : (acc_cnt > 0 ? acc_cnt - 1 : 0);
    mul_cnt <= i_multi_restart ? LAT : (mul_cnt > 0 ? mul_cnt - 1 : 0);
  end

  // busy is a level; the bench holds may stretch it to force the wait state
  assign o_access_busy = i_hold_acc || (acc_cnt > 0);
  assign o_multi_busy = i_hold_multi || (mul_cnt > 0);
endmodule // trs_chan_model

// [tb/trap_return_sequencer_test.sv]
// self-checking bench for the trap return sequencer
`include "trs_cfg.svh"
module trap_return_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import trs_pkg::*;
  `define CHK(act, exp) \
  begin \
    samples_checked++; \
    if ((act) !== (exp)) \
    begin \
      err_total++; \
      $display("unexpected at %0t: got %0h want %0h", $time, (act), (exp)); \
    end \
  end
  logic i_clk, i_rst_n, i_ret_req, i_ret_flush, i_status_we, i_pc_seq, i_inst_trap;
  logic i_fatal_alert, i_lsm_req, i_sbp_req, i_carry_upd, i_div_upd, hold_acc, hold_mul;
  logic acc_busy, mul_busy;
  trs_status_t i_old_status, i_status_wdata, o_status;
  trs_chan_t i_chan_ctl;
  logic [31:0] i_pc1, i_pc0, o_fetch_addr;
  logic [7:0] i_inst_vec, i_evt_req, i_evt_is_irq, o_take_vec;
  logic o_ret_block, o_btc_flush, o_acc_start, o_fetch_req, o_fetch_branch, o_fetch_rom;
  logic o_dec_load, o_exe_advance, o_multi_restart, o_ret_done, o_take, o_take_fatal;
  logic o_hold_regs, o_lsm_grant, o_sbp_we, o_carry_we, o_div_we;
  trs_vkind_t o_vec_kind;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;

  trs_trap_return_seq #(.NEV(8)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ret_req(i_ret_req), .i_ret_flush(i_ret_flush), .i_multi_busy(mul_busy),
    .i_access_busy(acc_busy), .i_old_status(i_old_status), .i_status_we(i_status_we),
    .i_status_wdata(i_status_wdata), .i_chan_ctl(i_chan_ctl), .i_pc1(i_pc1),
    .i_pc0(i_pc0), .i_pc_seq(i_pc_seq), .i_inst_trap(i_inst_trap),
    .i_inst_vec(i_inst_vec), .i_evt_req(i_evt_req), .i_evt_is_irq(i_evt_is_irq),
    .i_fatal_alert(i_fatal_alert), .i_lsm_req(i_lsm_req), .i_sbp_req(i_sbp_req),
    .i_carry_upd(i_carry_upd), .i_div_upd(i_div_upd), .o_status(o_status),
    .o_ret_block(o_ret_block), .o_btc_flush(o_btc_flush), .o_acc_start(o_acc_start),
    .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
    .o_fetch_branch(o_fetch_branch), .o_fetch_rom(o_fetch_rom), .o_dec_load(o_dec_load),
    .o_exe_advance(o_exe_advance), .o_multi_restart(o_multi_restart),
    .o_ret_done(o_ret_done), .o_take(o_take), .o_take_fatal(o_take_fatal),
    .o_take_vec(o_take_vec), .o_vec_kind(o_vec_kind), .o_hold_regs(o_hold_regs),
    .o_lsm_grant(o_lsm_grant), .o_sbp_we(o_sbp_we), .o_carry_we(o_carry_we),
    .o_div_we(o_div_we));

  // far side of the channel
  trs_chan_model #(.LAT(2)) i_chan (.i_clk(i_clk), .i_acc_start(o_acc_start),
    .i_multi_restart(o_multi_restart), .i_hold_acc(hold_acc), .i_hold_multi(hold_mul),
    .o_access_busy(acc_busy), .o_multi_busy(mul_busy));

  // clock, 5 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // expected class of a vector number
  function automatic trs_vkind_t kind_of(input logic [7:0] v);
    if (v == 8'h39)
      return TRS_VK_FMUL;
    if (v >= 8'h3A && v <= 8'h3F)
      return TRS_VK_EMU;
    return (v >= 8'h40) ? TRS_VK_INST : TRS_VK_SYS;
  endfunction

  // software write of the current status, then read back
  task automatic status_wr(input trs_status_t s);
    @(negedge i_clk);
    i_status_we = 1'b1;
    i_status_wdata = s;
    @(negedge i_clk);
    i_status_we = 1'b0;
    @(negedge i_clk);
    `CHK(o_status[12:0], s[12:0])
  endtask

  // one return sequence; w cycles of multiple-transfer wait, optional blocked trap
  task automatic do_ret(input int w, input bit trap_in);
    trs_status_t old;
    logic [6:0] ep;
    int s;
    old = trs_status_t'($urandom);
    repeat (3) @(negedge i_clk);
    i_ret_req = 1'b1;
    i_ret_flush = 1'($urandom);
    i_pc1 = $urandom;
    i_pc0 = $urandom;
    i_pc_seq = 1'($urandom);
    // corner cases: single and multiple restarts come up often
    i_chan_ctl = {1'($urandom_range(0, 3) != 0), 1'($urandom_range(0, 3) == 0), 1'($urandom)};
    i_old_status = old;
    hold_mul = (w > 0);
    for (int k = 0; k <= 9 + w; k++)
    begin
      @(negedge i_clk);
      // outputs after the k-th edge; the copy state shows at s == 2
      s = k - w + 1;
      i_ret_req = 1'b0;
      hold_mul = (k + 1 <= w);
      // maskable trap held only while the sequence is surely in its window
      i_inst_trap = trap_in && s >= 2 && s < 7;
      i_inst_vec = 8'h40;
      ep = {s == 3 && i_ret_flush, s == 4 && i_chan_ctl == 3'b100, s == 5 || s == 7,
            s == 6 || s == 8, s == 8, s == 9 && i_chan_ctl == 3'b101, s == 10};
      `CHK({o_btc_flush, o_acc_start, o_fetch_req, o_dec_load, o_exe_advance,
            o_multi_restart, o_ret_done}, ep)
      if (s >= 3 && s <= 8)
        `CHK(o_ret_block, 1'b1)
      if (s >= 3 && s <= 9)
        `CHK(o_take, 1'b0)
      if (s == 3)
        `CHK(o_status[12:0], old[12:0])
      if (s == 5)
        `CHK({o_fetch_addr, o_fetch_branch, o_fetch_rom}, {i_pc1, 1'b1, old[12]})
      if (s == 7)
        `CHK({o_fetch_addr, o_fetch_branch}, {i_pc0, !i_pc_seq})
      if (s == 10)
        `CHK(o_ret_block, 1'b0)
    end
  endtask

  // raise a trap or events with a random status; expect priority choice and vector
  task automatic take_chk(input bit inst, input logic [7:0] vec);
    trs_status_t st;
    logic [7:0] elig;
    logic [7:0] ev;
    bit found;
    // keep the all-event block clear but let the interrupt block vary
    st = trs_status_t'($urandom) & 14'h03FF;
    status_wr(st);
    @(negedge i_clk);
    i_evt_req = $urandom;
    i_evt_is_irq = $urandom;
    i_inst_trap = inst;
    i_inst_vec = vec;
    elig = i_evt_req & st.interrupt_mask_field & ~(i_evt_is_irq & {8{st.irq_block_flag}});
    ev = 8'h00;
    for (int i = 7; i >= 0; i--)
      if (elig[i])
        ev = `TRS_EVT_VEC_BASE + 8'(i);
    found = 1'b0;
    repeat (4)
    begin
      @(negedge i_clk);
      if (o_take === 1'b1 && !found)
      begin
        found = 1'b1;
        `CHK(o_take_vec, inst ? vec : ev)
        `CHK({o_status.freeze_flag, o_status.all_event_block_flag}, 2'b11)
        `CHK(o_status.irq_pending, |(i_evt_req & i_evt_is_irq))
        if (inst)
          `CHK(o_vec_kind, kind_of(vec))
      end
      i_inst_trap = 1'b0;
      i_evt_req = 8'h00;
    end
    `CHK(found, inst || (elig != 8'h00))
  endtask

  initial
  begin
    trs_status_t st;
    logic [3:0] r;
    logic [7:0] vl [8];
    bit found;
    {i_rst_n, i_ret_req, i_ret_flush, i_status_we, i_pc_seq, i_inst_trap} = '0;
    {i_fatal_alert, i_lsm_req, i_sbp_req, i_carry_upd, i_div_upd, hold_acc, hold_mul} = '0;
    {i_old_status, i_status_wdata, i_chan_ctl, i_pc1, i_pc0} = '0;
    {i_inst_vec, i_evt_req, i_evt_is_irq} = '0;
    void'($urandom(32));
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    `CHK({o_status, o_take, o_ret_done, o_fetch_req}, 17'h0_0000)
    // return sequences: plain, stalled by a multiple transfer, trap held off
    for (int n = 0; n < 12; n++)
      do_ret((n % 3 == 1) ? $urandom_range(1, 4) : 0, n % 3 == 2);
    // instruction vectors of every class, with boundaries
    vl = '{8'($urandom_range(0, 56)), 8'h39, 8'h3A, 8'($urandom_range(58, 63)), 8'h3F,
           8'h40, 8'($urandom_range(64, 255)), 8'hFF};
    foreach (vl[i])
      take_chk(1'b1, vl[i]);
    // random external events against masks and the interrupt block
    repeat (12)
      take_chk(1'b0, 8'h00);
    // freeze guards on channel, pointer and alu status updates
    repeat (10)
    begin
      st = trs_status_t'($urandom) & 14'h00FF;
      st.freeze_flag = 1'($urandom);
      status_wr(st);
      r = $urandom;
      {i_lsm_req, i_sbp_req, i_carry_upd, i_div_upd} = r;
      repeat (2) @(negedge i_clk);
      `CHK({o_lsm_grant, o_sbp_we, o_carry_we, o_div_we}, r & {4{!st.freeze_flag}})
      `CHK(o_hold_regs, st.freeze_flag)
      {i_lsm_req, i_sbp_req, i_carry_upd, i_div_upd} = 4'h0;
    end
    // fatal alert while everything is blocked and a return waits on an access
    status_wr(14'h0400);
    @(negedge i_clk);
    i_ret_req = 1'b1;
    hold_acc = 1'b1;
    @(negedge i_clk);
    i_ret_req = 1'b0;
    i_fatal_alert = 1'b1;
    found = 1'b0;
    repeat (10)
    begin
      @(negedge i_clk);
      if (o_take_fatal === 1'b1 && !found)
      begin
        found = 1'b1;
        `CHK({o_take, o_fetch_req, o_fetch_addr, o_fetch_branch, o_fetch_rom},
             {2'b11, `TRS_FATAL_ROM_ADDR, 2'b11})
        `CHK(o_status[12:10], 3'b111)
      end
    end
    `CHK(found, 1'b1)
    i_fatal_alert = 1'b0;
    hold_acc = 1'b0;
    repeat (14)
    begin
      @(negedge i_clk);
      `CHK(o_ret_done, 1'b0)
    end
    finish_test();
  end
endmodule // trap_return_sequencer_test
